// [pkg/hrc_defines.svh]
/*
  Constants of the halt release control block: register offsets, reset values,
  field positions and timing counts.
  Assumes a 100 MHz pclk and a 32-bit APB register bus.
*/
`ifndef HRC_DEFINES_SVH
`define HRC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define HRC_OFF_KEY_DIR     8'h00
`define HRC_OFF_KEY_OUT     8'h04
`define HRC_OFF_KEY_PULLDN  8'h08
`define HRC_OFF_KEY_ADC     8'h0C
`define HRC_OFF_KEY_IN      8'h10
`define HRC_OFF_TMR_SEL     8'h14
`define HRC_OFF_TMR_CARRY   8'h18
`define HRC_OFF_IRQ_REQ     8'h1C
`define HRC_OFF_IRQ_EN      8'h20
`define HRC_OFF_GLOBAL      8'h24
`define HRC_OFF_STATUS      8'h28

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define HRC_RST_KEY_DIR     4'h0
`define HRC_RST_KEY_OUT     4'h0
`define HRC_RST_KEY_PULLDN  4'hF
`define HRC_RST_KEY_ADC     4'h0
`define HRC_RST_TMR_SEL     2'h0
`define HRC_RST_IRQ_EN      4'h0

// ----------------------------------------------------------------------------
// halt operand bit positions
// ----------------------------------------------------------------------------
`define HRC_OP_KEY_BIT      0
`define HRC_OP_CARRY_BIT    1
`define HRC_OP_INTR_BIT     3

// ----------------------------------------------------------------------------
// interrupt sources, index 0 has the highest priority
// ----------------------------------------------------------------------------
`define HRC_NSRC            4
`define HRC_VEC_EXT0        16'h000B
`define HRC_VEC_EXT1        16'h000A
`define HRC_VEC_EXT2        16'h0009
`define HRC_VEC_TMR0        16'h0006

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define HRC_CLK_NS          10
`define HRC_MS_NS           1000000
`define HRC_MS_CYCLES       (`HRC_MS_NS / `HRC_CLK_NS)
`define HRC_IVL0_MS         100
`define HRC_IVL1_MS         50
`define HRC_IVL2_MS         20
`define HRC_IVL3_MS         10

`endif

// [pkg/hrc_pkg.sv]
/*
  Types of the halt release control block.
  Assumes hrc_defines.svh for all numeric constants.
*/
package hrc_pkg;

  // --------------------------------------------------------------------------
  // sequencer state and halt operand
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    HRC_RUN  = 2'h0,
    HRC_HALT = 2'h1,
    HRC_WAKE = 2'h3
  } hrc_state_t;

  typedef struct packed {
    logic intr;
    logic rsvd;
    logic carry;
    logic key;
  } hrc_halt_op_t;

  // --------------------------------------------------------------------------
  // answer to the cpu sequencer
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        vector_take;
    logic        resume;
    logic [15:0] vector_addr;
  } hrc_cpu_evt_t;

endpackage : hrc_pkg

// [rtl/hrc_halt_release_control.sv]
/*
  Halt release control: halt state of the cpu, wake-up by key port, basic timer
  carry or pending enabled interrupt (global enable not needed), interrupt request/enable flags, vectoring.
  Assumes a cpu sequencer that pulses halt_exec and return_from_interrupt_exec on pclk and
  honours cpu_clk_en, vector_take and resume; peripherals pulse irq_event.
*/
`timescale 1ns/10ps
`include "hrc_defines.svh"

module hrc_halt_release_control
  import hrc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `HRC_MS_CYCLES
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // cpu sequencer
  input  wire logic                  halt_exec,
  input  wire logic [3:0]            halt_operand,
  input  wire logic                  return_from_interrupt_exec,
  output logic                       cpu_clk_en,
  output hrc_cpu_evt_t               cpu_evt,
  // interrupt sources
  input  wire logic [`HRC_NSRC-1:0]  irq_event,
  // key input port pins
  input  wire logic [3:0]            key_in,
  output logic      [3:0]            key_out,
  output logic      [3:0]            key_oe,
  output logic      [3:0]            key_pulldown_en
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [`HRC_NSRC-1:0] hrc_first(input logic [`HRC_NSRC-1:0] v);
    logic [`HRC_NSRC-1:0] r;
    r = '0;
    for (int i = `HRC_NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : hrc_first

  function automatic logic [15:0] hrc_vec(input logic [`HRC_NSRC-1:0] one);
    logic [15:0] a;
    a = 16'h0000;
    if (one[0]) a = `HRC_VEC_EXT0;
    if (one[1]) a = `HRC_VEC_EXT1;
    if (one[2]) a = `HRC_VEC_EXT2;
    if (one[3]) a = `HRC_VEC_TMR0;
    return a;
  endfunction : hrc_vec

  // --------------------------------------------------------------------------
  // state and registers
  // --------------------------------------------------------------------------
  hrc_state_t           state_r;
  hrc_halt_op_t         op_r;
  logic [3:0]           key_dir_r;
  logic [3:0]           key_out_r;
  logic [3:0]           key_pulldn_r;
  logic [3:0]           key_adc_r;
  logic [3:0]           key_s1_r;
  logic [3:0]           key_s2_r;
  logic [3:0]           key_s3_r;
  logic [3:0]           key_val_r;
  logic [1:0]           tmr_sel_r;
  logic [16:0]          ms_cnt_r;
  logic [6:0]           ivl_cnt_r;
  logic                 carry_r;
  logic [`HRC_NSRC-1:0] irq_req_r;
  logic [`HRC_NSRC-1:0] irq_en_r;
  logic [`HRC_NSRC-1:0] irq_clr_r;
  logic [`HRC_NSRC-1:0] irq_clr2_r;
  logic                 ge_r;
  logic                 in_service_r;
  logic                 wake_int_r;
  logic [15:0]          last_vec_r;

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  logic acc;
  logic wr;
  logic map_hit;
  assign acc = psel & penable & pready;
  assign wr  = acc & pwrite;
  always_comb begin
    unique case (paddr)
      `HRC_OFF_KEY_DIR, `HRC_OFF_KEY_OUT, `HRC_OFF_KEY_PULLDN, `HRC_OFF_KEY_ADC,
      `HRC_OFF_KEY_IN, `HRC_OFF_TMR_SEL, `HRC_OFF_TMR_CARRY, `HRC_OFF_IRQ_REQ,
      `HRC_OFF_IRQ_EN, `HRC_OFF_GLOBAL, `HRC_OFF_STATUS: map_hit = 1'b1;
      default:                                           map_hit = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // key input port
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_dir_r    <= `HRC_RST_KEY_DIR;
      key_out_r    <= `HRC_RST_KEY_OUT;
      key_pulldn_r <= `HRC_RST_KEY_PULLDN;
      key_adc_r    <= `HRC_RST_KEY_ADC;
    end else if (wr) begin
      if (paddr == `HRC_OFF_KEY_DIR)    key_dir_r    <= pwdata[3:0];
      if (paddr == `HRC_OFF_KEY_OUT)    key_out_r    <= pwdata[3:0];
      if (paddr == `HRC_OFF_KEY_PULLDN) key_pulldn_r <= pwdata[3:0];
      if (paddr == `HRC_OFF_KEY_ADC)    key_adc_r    <= pwdata[3:0];
    end
  end

  // three-stage synchroniser, level accepted once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_s1_r  <= 4'h0;
      key_s2_r  <= 4'h0;
      key_s3_r  <= 4'h0;
      key_val_r <= 4'h0;
    end else begin
      key_s1_r <= key_in;
      key_s2_r <= key_s1_r;
      key_s3_r <= key_s2_r;
      for (int i = 0; i < 4; i++) begin
        if (key_s2_r[i] == key_s3_r[i]) key_val_r[i] <= key_s3_r[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_out         <= `HRC_RST_KEY_OUT;
      key_oe          <= 4'h0;
      key_pulldown_en <= `HRC_RST_KEY_PULLDN;
    end else begin
      key_out         <= key_out_r;
      key_oe          <= key_dir_r & ~key_adc_r;
      key_pulldown_en <= key_pulldn_r & ~key_dir_r;
    end
  end

  // --------------------------------------------------------------------------
  // basic timer, runs regardless of halt
  // --------------------------------------------------------------------------
  logic       ms_tick;
  logic [6:0] ivl_len;
  assign ms_tick = (ms_cnt_r == 17'(MS_CYCLES - 1));
  always_comb begin
    unique case (tmr_sel_r)
      2'h0: ivl_len = 7'(`HRC_IVL0_MS);
      2'h1: ivl_len = 7'(`HRC_IVL1_MS);
      2'h2: ivl_len = 7'(`HRC_IVL2_MS);
      2'h3: ivl_len = 7'(`HRC_IVL3_MS);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_sel_r <= `HRC_RST_TMR_SEL;
      ms_cnt_r  <= 17'h0;
      ivl_cnt_r <= 7'h0;
    end else begin
      if (wr && paddr == `HRC_OFF_TMR_SEL) tmr_sel_r <= pwdata[1:0];
      ms_cnt_r <= ms_tick ? 17'h0 : ms_cnt_r + 17'h1;
      if (ms_tick) ivl_cnt_r <= (ivl_cnt_r >= ivl_len - 7'h1) ? 7'h0 : ivl_cnt_r + 7'h1;
    end
  end

  logic carry_set;
  assign carry_set = ms_tick && (ivl_cnt_r >= ivl_len - 7'h1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_r <= 1'b0;
    end else if (carry_set) begin
      carry_r <= 1'b1;
    end else if (wr && paddr == `HRC_OFF_TMR_CARRY && pwdata[0]) begin
      carry_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // interrupt flags and acceptance
  // --------------------------------------------------------------------------
  logic [`HRC_NSRC-1:0] pend;
  logic [`HRC_NSRC-1:0] pick;
  logic                 take_run;
  logic                 take_wake;
  logic                 vec_take;
  assign pend      = irq_req_r & irq_en_r;
  assign pick      = hrc_first(pend);
  assign take_run  = (state_r == HRC_RUN) && ge_r && (|pend) && (!in_service_r || return_from_interrupt_exec);
  assign take_wake = (state_r == HRC_WAKE) && wake_int_r && ge_r && (|pend);
  assign vec_take  = take_run || take_wake;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_r  <= '0;
      irq_clr_r  <= '0;
      irq_clr2_r <= '0;
    end else begin
      // a software clear lands two cycles late, so a halt issued right after still sees the flag
      irq_clr_r  <= (wr && paddr == `HRC_OFF_IRQ_REQ) ? pwdata[`HRC_NSRC-1:0] : '0;
      irq_clr2_r <= irq_clr_r;
      irq_req_r  <= (irq_req_r & ~irq_clr2_r & ~(vec_take ? pick : '0)) | irq_event;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= `HRC_RST_IRQ_EN;
    end else if (wr && paddr == `HRC_OFF_IRQ_EN) begin
      irq_en_r <= pwdata[`HRC_NSRC-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ge_r <= 1'b0;
    end else if (vec_take) begin
      ge_r <= 1'b0;
    end else if (wr && paddr == `HRC_OFF_GLOBAL) begin
      ge_r <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_service_r <= 1'b0;
    end else if (vec_take) begin
      in_service_r <= 1'b1;
    end else if (return_from_interrupt_exec) begin
      in_service_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // halt sequencer
  // --------------------------------------------------------------------------
  logic wake_key;
  logic wake_carry;
  logic wake_int;
  assign wake_key   = op_r.key   && (|(key_val_r & ~key_dir_r & ~key_adc_r));
  assign wake_carry = op_r.carry && carry_r;
  assign wake_int   = op_r.intr  && (|pend);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= HRC_RUN;
      op_r       <= '0;
      wake_int_r <= 1'b0;
    end else begin
      unique case (state_r)
        HRC_RUN: begin
          if (halt_exec && !take_run) begin
            op_r    <= halt_operand;
            state_r <= HRC_HALT;
          end
        end
        HRC_HALT: begin
          // operand 0000B never wakes, only presetn ends it
          if (wake_key || wake_carry || wake_int) begin
            wake_int_r <= wake_int;
            state_r    <= HRC_WAKE;
          end
        end
        HRC_WAKE: begin
          wake_int_r <= 1'b0;
          state_r    <= HRC_RUN;
        end
        default: state_r <= HRC_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en <= 1'b1;
      cpu_evt    <= '0;
      last_vec_r <= 16'h0000;
    end else begin
      cpu_clk_en          <= !(state_r == HRC_HALT) && !(state_r == HRC_RUN && halt_exec && !take_run);
      cpu_evt.vector_take <= vec_take;
      cpu_evt.resume      <= (state_r == HRC_WAKE) && !take_wake;
      cpu_evt.vector_addr <= vec_take ? hrc_vec(pick) : 16'h0000;
      if (vec_take) last_vec_r <= hrc_vec(pick);
    end
  end

  // --------------------------------------------------------------------------
  // apb answer, one wait cycle
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !map_hit;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite) begin
        unique case (paddr)
          `HRC_OFF_KEY_DIR:    prdata[3:0] <= key_dir_r;
          `HRC_OFF_KEY_OUT:    prdata[3:0] <= key_out_r;
          `HRC_OFF_KEY_PULLDN: prdata[3:0] <= key_pulldn_r;
          `HRC_OFF_KEY_ADC:    prdata[3:0] <= key_adc_r;
          `HRC_OFF_KEY_IN:     prdata[3:0] <= key_val_r;
          `HRC_OFF_TMR_SEL:    prdata[1:0] <= tmr_sel_r;
          `HRC_OFF_TMR_CARRY:  prdata[0]   <= carry_r;
          `HRC_OFF_IRQ_REQ:    prdata[`HRC_NSRC-1:0] <= irq_req_r;
          `HRC_OFF_IRQ_EN:     prdata[`HRC_NSRC-1:0] <= irq_en_r;
          `HRC_OFF_GLOBAL:     prdata[0]   <= ge_r;
          `HRC_OFF_STATUS:     prdata      <= {last_vec_r, 8'h00, 2'h0, in_service_r, state_r == HRC_HALT, op_r};
          default:             prdata      <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : hrc_halt_release_control

// [dv/hrc_checker_assertions.sv]
/*
  Port-level checks of the halt release control block.
  Assumes hrc_pkg and hrc_defines.svh; bound to the design top below.
*/
`timescale 1ns/10ps
`include "hrc_defines.svh"
module hrc_checker
  import hrc_pkg::*;
(
  // clock and reset
  input wire logic         pclk,
  input wire logic         presetn,
  // apb
  input wire logic         psel,
  input wire logic         penable,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  // cpu side
  input wire logic         halt_exec,
  input wire logic [3:0]   halt_operand,
  input wire logic         cpu_clk_en,
  input wire hrc_cpu_evt_t cpu_evt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------------
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  chk_apb_answer: assert property (s_setup ##1 (psel && penable) |-> s_answer)
    else $error("apb answer not in second access cycle");
  chk_idle_rdata: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  // ----------------------------------------------------------------------
  // halt and wake
  // ----------------------------------------------------------------------
  chk_halt_cause: assert property ($fell(cpu_clk_en) |-> $past(halt_exec))
    else $error("cpu clock stopped without halt");
  chk_halt_floor: assert property ($fell(cpu_clk_en) |-> !cpu_clk_en ##1 !cpu_clk_en)
    else $error("halt shorter than two cycles");
  chk_zero_hold: assert property ($fell(cpu_clk_en) && $past(halt_operand) == 4'h0
    |-> !cpu_clk_en [*8])
    else $error("zero operand halt ended");
  chk_wake_kind: assert property ($rose(cpu_clk_en) |-> cpu_evt.resume ^ cpu_evt.vector_take)
    else $error("wake without single resume or vector");
  chk_vec_table: assert property (cpu_evt.vector_take |-> cpu_evt.vector_addr inside
    {`HRC_VEC_EXT0, `HRC_VEC_EXT1, `HRC_VEC_EXT2, `HRC_VEC_TMR0})
    else $error("vector outside table");
  chk_vec_pulse: assert property (cpu_evt.vector_take |=> !cpu_evt.vector_take)
    else $error("vector pulse longer than one cycle");
endmodule : hrc_checker

bind hrc_halt_release_control hrc_checker u_hrc_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .halt_exec(halt_exec), .halt_operand(halt_operand),
  .cpu_clk_en(cpu_clk_en), .cpu_evt(cpu_evt));

// [dv/hrc_key_pad.sv]
/*
  Key port pads: resolves pin level from drive, key press and pull-down.
  Assumes press comes from the bench; key_in feeds the design.
*/
`timescale 1ns/10ps
module hrc_key_pad (
  // clock
  input wire logic       pclk,
  // design side
  input wire logic [3:0] key_out,
  input wire logic [3:0] key_oe,
  input wire logic [3:0] key_pulldown_en,
  // outside world
  input wire logic [3:0] press,
  output logic     [3:0] key_in
);
  initial key_in = 4'h0;
  // an undriven, unpressed pin with no pull toggles so it is never read as steady
  always @(posedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      if (key_oe[i]) key_in[i] <= key_out[i];
      else if (press[i]) key_in[i] <= 1'b1;
      else if (key_pulldown_en[i]) key_in[i] <= 1'b0;
      else key_in[i] <= ~key_in[i];
    end
  end
endmodule : hrc_key_pad

// [dv/test_halt_release_control.sv]
/*
  Self-checking bench of the halt release control block.
  Assumes hrc_pkg, hrc_defines.svh and the key pad model.
*/
`timescale 1ns/10ps
`include "hrc_defines.svh"
`define CHK(g,e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module test_halt_release_control;
  import hrc_pkg::*;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic         halt_exec = 0, return_from_interrupt_exec = 0, pready, pslverr, cpu_clk_en, rerr, qs;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0, prdata, rdat;
  logic [3:0]   halt_operand = 4'h0, irq_event = 4'h0, press = 4'h0;
  logic [3:0]   key_in, key_out, key_oe, key_pd;
  hrc_cpu_evt_t cpu_evt, ev;
  int           bad_count = 0, n_tests = 0, cyc = 0, n;
  // ----------------------------------------------------------------------
  // design and pads
  // ----------------------------------------------------------------------
  hrc_halt_release_control #(.MS_CYCLES(10)) u_hrc_halt_release_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_exec(halt_exec), .halt_operand(halt_operand), .return_from_interrupt_exec(return_from_interrupt_exec),
    .cpu_clk_en(cpu_clk_en), .cpu_evt(cpu_evt), .irq_event(irq_event), .key_in(key_in),
    .key_out(key_out), .key_oe(key_oe), .key_pulldown_en(key_pd));
  hrc_key_pad u_hrc_key_pad (.pclk(pclk), .key_out(key_out), .key_oe(key_oe),
    .key_pulldown_en(key_pd), .press(press), .key_in(key_in));
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task wrap_up;
    $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task stuck; bad_count++; wrap_up(); endtask : stuck
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk); psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1'b1;
    for (i = 0; i < 20; i++) begin @(posedge pclk); if (pready === 1'b1) break; end
    if (i == 20) stuck();
    rdat = prdata; rerr = pslverr; psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task hlt(input logic [3:0] op, input logic now);
    if (!now) @(posedge pclk);
    halt_exec <= 1'b1; halt_operand <= op;
    @(posedge pclk); halt_exec <= 1'b0;
  endtask : hlt
  task pulse(input logic [3:0] v); @(posedge pclk); irq_event <= v; @(posedge pclk); irq_event <= 4'h0; endtask : pulse
  task ret_pulse; @(posedge pclk); return_from_interrupt_exec <= 1'b1; @(posedge pclk); return_from_interrupt_exec <= 1'b0; endtask : ret_pulse
  task wake;
    for (n = 0; n < 1500; n++) begin #1; if (cpu_evt.vector_take | cpu_evt.resume) break; @(posedge pclk); end
    if (n == 1500) stuck();
    ev = cpu_evt;
  endtask : wake
  task quiet(input int k);
    qs = 1'b0;
    repeat (k) begin @(posedge pclk); #1; qs = qs | cpu_evt.vector_take | cpu_evt.resume; end
  endtask : quiet
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task t_regs;
    apb(0, `HRC_OFF_KEY_PULLDN, 0); `CHK(rdat, 32'h0000000F)
    `CHK(key_pd, 4'hF)
    apb(1, `HRC_OFF_KEY_DIR, 32'h5); apb(1, `HRC_OFF_KEY_OUT, 32'h1);
    @(posedge pclk); #1 `CHK({key_oe, key_out}, 8'h51)
    apb(1, `HRC_OFF_KEY_DIR, 0); apb(0, 8'h3C, 0); `CHK({rerr, rdat}, 33'h100000000)
  endtask : t_regs
  task t_key;
    apb(1, `HRC_OFF_KEY_ADC, 32'h2); press <= 4'h2;
    hlt(4'h1, 0); quiet(30); `CHK(qs, 1'b0)
    press <= 4'h6; wake(); `CHK(ev.resume, 1'b1)
    apb(1, `HRC_OFF_KEY_ADC, 0); press <= 4'h8; quiet(8);
    hlt(4'hB, 0); wake(); `CHK({ev.resume, n < 6}, 2'b11)
    apb(0, `HRC_OFF_KEY_IN, 0); `CHK(rdat[3], 1'b1)
    press <= 4'h0;
  endtask : t_key
  task t_carry;
    int ivl[4] = '{`HRC_IVL0_MS, `HRC_IVL1_MS, `HRC_IVL2_MS, `HRC_IVL3_MS};
    int t0;
    for (int s = 0; s < 4; s++) begin
      apb(1, `HRC_OFF_TMR_SEL, s);
      for (int k = 0; k < 3; k++) begin
        apb(1, `HRC_OFF_TMR_CARRY, 1); hlt(4'h2, 0); wake(); `CHK(ev.resume, 1'b1)
        if (k == 2) `CHK(cyc - t0, ivl[s] * 10)
        t0 = cyc;
      end
      apb(0, `HRC_OFF_TMR_CARRY, 0); `CHK(rdat[0], 1'b1)
    end
  endtask : t_carry
  task t_intr;
    apb(1, `HRC_OFF_IRQ_EN, 32'h9); apb(1, `HRC_OFF_GLOBAL, 1); hlt(4'h8, 0);
    pulse(4'h2); quiet(20); `CHK(qs, 1'b0)
    pulse(4'h9); wake(); `CHK(ev, {2'b10, `HRC_VEC_EXT0})
    apb(1, `HRC_OFF_GLOBAL, 1); ret_pulse(); wake(); `CHK(ev, {2'b10, `HRC_VEC_TMR0})
    `CHK(n < 3, 1'b1)
    apb(1, `HRC_OFF_GLOBAL, 1); ret_pulse(); quiet(10); `CHK(qs, 1'b0)
    apb(1, `HRC_OFF_IRQ_REQ, 32'hF);
  endtask : t_intr
  task t_off;
    apb(1, `HRC_OFF_IRQ_EN, 1); apb(1, `HRC_OFF_GLOBAL, 0); hlt(4'h8, 0);
    pulse(4'h1); wake(); `CHK({ev.vector_take, ev.resume}, 2'b01)
    apb(0, `HRC_OFF_IRQ_REQ, 0); `CHK(rdat[0], 1'b1)
    apb(1, `HRC_OFF_IRQ_REQ, 1); hlt(4'h8, 1); wake(); `CHK(n < 6, 1'b1)
    apb(1, `HRC_OFF_IRQ_REQ, 1); @(posedge pclk); hlt(4'h8, 0); quiet(20); `CHK(qs, 1'b0)
    pulse(4'h1); wake(); `CHK(ev.resume, 1'b1)
    apb(1, `HRC_OFF_IRQ_REQ, 1);
  endtask : t_off
  task t_zero;
    apb(1, `HRC_OFF_TMR_SEL, 3); hlt(4'h0, 0); press <= 4'hF;
    apb(0, `HRC_OFF_STATUS, 0); `CHK(rdat[4:0], 5'h10)
    `CHK(cpu_clk_en, 1'b0)
    quiet(250); `CHK(qs, 1'b0)
    @(posedge pclk); presetn <= 1'b0; press <= 4'h0;
    repeat (4) @(posedge pclk);
    #1 `CHK({cpu_clk_en, key_pd}, 5'h1F)
    @(posedge pclk); presetn <= 1'b1;
  endtask : t_zero
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs(); t_key(); t_carry(); t_intr(); t_off(); t_zero();
    wrap_up();
  end
endmodule : test_halt_release_control
